//--- rtl/mbac_top.sv
`timescale 1ns/1ns
`default_nettype none
module mbac_top (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic refresh_request_n_in,
	input wire logic dma_request_n_in,
	input wire logic [3:0] cpu_request_n_in,
	input wire mbac_pkg::mbac_busq_t busq_in,
	input wire mbac_pkg::mbac_err_t mem_err_in,
	output mbac_pkg::mbac_grant_t grant_out,
	output logic cycle_go_out,
	output logic cycle_done_n_out,
	output logic refresh_func_code_n_out,
	output logic func_code_bit1_n_out,
	output logic func_code_bit0_n_out,
	output logic uncorrectable_error_n_out,
	output logic any_error_out
);
	import mbac_pkg::*;

	// ***********************************************
	// Request capture
	// ***********************************************
	logic [NUM_REQ-1:0] req_sync_r;
	wire logic [NUM_REQ-1:0] req_raw;
	assign req_raw = ~{cpu_request_n_in, dma_request_n_in,
		refresh_request_n_in};

	// Requests already launch on a clock edge, so one register suffices
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in)
			req_sync_r <= '0;
		else
			req_sync_r <= req_raw;
	end

	// ***********************************************
	// Arbitration and cycle sequencing
	// ***********************************************
	wire logic [NUM_REQ-1:0] win;
	mbac_prio u_prio (
		.req_in(req_sync_r),
		.win_out(win)
	);

	logic busy_r;
	logic [3:0] st_r;
	logic [3:0] st_nxt;
	logic [NUM_REQ-1:0] own_r;
	logic [NUM_REQ-1:0] own_nxt;
	logic err_seen_r;
	logic uc_seen_r;
	logic go_r;
	logic done_n_r;
	logic uc_n_r;
	logic any_r;
	logic grant_on_r;

	mbac_cyc_t cyc;
	wire logic [1:0] low_code;
	wire logic last_st;
	wire logic start;
	wire logic [3:0] cyc_len;
	wire logic [3:0] go_len;
	wire logic is_read;
	wire logic err_cyc;
	wire logic err_now;
	wire logic [3:0] len_ahead;
	wire logic mid_cyc;
	wire logic go_nxt;
	wire logic done_nxt;
	wire logic any_nxt;
	wire logic uc_nxt;

	// Length of the cycle in progress; a read stretches only on error
	function automatic logic [3:0] len_of(input mbac_cyc_t c,
		input logic err);
		unique case (c)
		MBAC_CYC_RFSH: len_of = LEN_RFSH;
		MBAC_CYC_WR32: len_of = LEN_WR32;
		MBAC_CYC_READ: len_of = err ? LEN_RD_ERR : LEN_RD_OK;
		MBAC_CYC_RMW: len_of = LEN_RMW;
		default: len_of = LEN_RFSH;
		endcase
	endfunction

	assign cyc_len = len_of(cyc, err_seen_r);
	assign go_len = (cyc == MBAC_CYC_WR32) ? GO_LEN_WR32 : GO_LEN;
	assign last_st = busy_r && (st_r == cyc_len - 4'h1);
	// New grants only when idle or on the done state
	assign start = (|req_sync_r) && (!busy_r || last_st);
	assign is_read = (cyc == MBAC_CYC_READ) || (cyc == MBAC_CYC_RMW);
	// Error outcome as known one state early, so strobes registered at
	// the end of S8 already see it
	assign err_now = (busy_r && st_r == ST_ERR_KNOWN) ?
		(mem_err_in.corr | mem_err_in.uncorr) : err_seen_r;
	assign len_ahead = len_of(cyc, err_now);
	assign err_cyc = is_read && err_now;

	mbac_fcode u_fcode (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.load_in(start),
		.idle_in(last_st),
		.rfsh_in(win[REQ_RFSH]),
		.busq_in(busq_in),
		.cyc_out(cyc),
		.code_out(low_code)
	);

	always_comb begin
		st_nxt = st_r + 4'h1;
		own_nxt = own_r;
		if (start) begin
			st_nxt = 4'h0;
			own_nxt = win;
		end else if (last_st || !busy_r) begin
			st_nxt = 4'h0;
			own_nxt = '0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			busy_r <= 1'b0;
			st_r <= 4'h0;
			own_r <= '0;
		end else begin
			busy_r <= start || (busy_r && !last_st);
			st_r <= st_nxt;
			own_r <= own_nxt;
		end
	end

	// ***********************************************
	// Error capture and strobes
	// ***********************************************
	// Error status is sampled once, when the check completes
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || start) begin
			err_seen_r <= 1'b0;
			uc_seen_r <= 1'b0;
		end else if (busy_r && st_r == ST_ERR_KNOWN) begin
			err_seen_r <= mem_err_in.corr | mem_err_in.uncorr;
			uc_seen_r <= mem_err_in.uncorr;
		end
	end

	assign mid_cyc = busy_r && !last_st;
	assign go_nxt = start || (mid_cyc && (st_r + 4'h1 < go_len));
	// Done looks one state ahead, hence the early error outcome
	assign done_nxt = mid_cyc && (st_r + 4'h2 == len_ahead);
	assign any_nxt = busy_r && err_cyc &&
		(st_r + 4'h1 == ST_ANY_ERR);
	assign uc_nxt = mid_cyc && is_read && uc_seen_r &&
		(st_r + 4'h1 >= ST_UC_ERR);

	// Strobes registered on state; they describe the state entered
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			go_r <= 1'b0;
			grant_on_r <= 1'b0;
			done_n_r <= 1'b1;
			uc_n_r <= 1'b1;
			any_r <= 1'b0;
		end else begin
			go_r <= go_nxt;
			grant_on_r <= go_nxt;
			done_n_r <= !done_nxt;
			any_r <= any_nxt;
			uc_n_r <= !uc_nxt;
		end
	end

	// ***********************************************
	// Outputs
	// ***********************************************
	wire logic [NUM_REQ-1:0] grant_act;
	assign grant_act = grant_on_r ? own_r : '0;
	// Grant drops with go; requesters must release the bus then
	assign grant_out = '{refresh_grant_n: !grant_act[REQ_RFSH],
		dma_grant_n: !grant_act[REQ_DMA],
		cpu_grant_n: ~grant_act[REQ_CPU0+3:REQ_CPU0]};
	assign cycle_go_out = go_r;
	assign cycle_done_n_out = done_n_r;
	assign refresh_func_code_n_out = !grant_act[REQ_RFSH];
	assign func_code_bit1_n_out = low_code[1];
	assign func_code_bit0_n_out = low_code[0];
	assign uncorrectable_error_n_out = uc_n_r;
	assign any_error_out = any_r;

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	grant_onehot_a: assert property ($onehot0(grant_act))
		else $error("more than one grant active");
	grant_go_a: assert property ($onehot(grant_act) == go_r)
		else $error("grant not matching go");
	prio_win_a: assert property (
		start && req_sync_r[REQ_RFSH] |=> own_r[REQ_RFSH])
		else $error("refresh request not served first");
	req_to_go_a: assert property (
		!busy_r && req_sync_r == '0 && req_raw != '0 |=> ##1 go_r)
		else $error("request not served two clocks later");
	sync_delay_a: assert property (
		req_raw != 6'h00 && !busy_r |-> ##1 req_sync_r == $past(req_raw))
		else $error("request not registered");
	no_preempt_a: assert property (
		busy_r && !last_st |=> $stable(own_r))
		else $error("grant changed mid cycle");
	b2b_go_a: assert property (
		last_st && req_sync_r != '0 |=> go_r && st_r == 4'h0)
		else $error("next cycle not started after done");

	go_wr_len_a: assert property (
		go_r && st_r == 4'h0 && busy_r && cyc == MBAC_CYC_WR32
		|-> go_r[*6] ##1 !go_r)
		else $error("full write go not six states");
	go_rd_len_a: assert property (
		go_r && st_r == 4'h0 && busy_r && cyc == MBAC_CYC_READ
		|-> go_r[*5] ##1 !go_r)
		else $error("read go not five states");
	go_rmw_len_a: assert property (
		go_r && st_r == 4'h0 && busy_r && cyc == MBAC_CYC_RMW
		|-> go_r[*5] ##1 !go_r)
		else $error("rmw go not five states");

	rfsh_len_a: assert property (
		$rose(busy_r) && cyc == MBAC_CYC_RFSH |-> ##7 !cycle_done_n_out)
		else $error("refresh length wrong");
	wr_len_a: assert property (
		$rose(busy_r) && cyc == MBAC_CYC_WR32 |-> ##7 !cycle_done_n_out)
		else $error("full write length wrong");
	rd_ok_len_a: assert property (
		$rose(busy_r) && cyc == MBAC_CYC_READ ##9 !err_seen_r
		|-> !cycle_done_n_out)
		else $error("clean read not ten states");
	rd_err_len_a: assert property (
		$rose(busy_r) && cyc == MBAC_CYC_READ ##9 err_seen_r
		|-> ##3 !cycle_done_n_out)
		else $error("read with error not thirteen states");
	rmw_done_at_a: assert property (
		$rose(busy_r) && cyc == MBAC_CYC_RMW |-> ##14 !cycle_done_n_out)
		else $error("rmw done not in S14");
	done_last_a: assert property (
		!cycle_done_n_out |-> last_st)
		else $error("done outside final state");
	done_once_a: assert property (
		!cycle_done_n_out |=> cycle_done_n_out)
		else $error("done longer than one state");

	code_idle_a: assert property (
		!busy_r |-> {func_code_bit1_n_out, func_code_bit0_n_out} == FC_NOP)
		else $error("function code not idle between cycles");
	rfsh_code_a: assert property (
		!refresh_func_code_n_out |-> go_r && cyc == MBAC_CYC_RFSH)
		else $error("refresh code outside refresh grant");

	any_err_s9_a: assert property (
		any_r |-> busy_r && st_r == ST_ANY_ERR && is_read)
		else $error("any error outside S9");
	any_once_a: assert property (
		any_r |=> !any_r)
		else $error("any error longer than one state");
	uc_s10_a: assert property (
		$fell(uc_n_r) |-> busy_r && st_r == ST_UC_ERR)
		else $error("uncorrectable error not starting in S10");
	uc_hold_a: assert property (
		!uc_n_r && cycle_done_n_out |=> !uc_n_r)
		else $error("uncorrectable error not held to done");
	uc_end_a: assert property (
		!cycle_done_n_out |=> uc_n_r)
		else $error("uncorrectable error held past done");

	// ***********************************************
	// Coverage of main scenarios
	// ***********************************************
	rfsh_cov_c: cover property ($rose(busy_r) && cyc == MBAC_CYC_RFSH);
	rd_err_cov_c: cover property (any_r && cyc == MBAC_CYC_READ);
	rmw_cov_c: cover property ($rose(busy_r) && cyc == MBAC_CYC_RMW);
	wr_cov_c: cover property ($rose(busy_r) && cyc == MBAC_CYC_WR32);
	b2b_cov_c: cover property (last_st && start);
endmodule
`default_nettype wire

//--- rtl/mbac_pkg.sv
`default_nettype none
package mbac_pkg;
	// ***********************************************
	// Requesters and priority positions
	// ***********************************************
	localparam int unsigned NUM_REQ = 6;
	localparam int unsigned REQ_RFSH = 0;
	localparam int unsigned REQ_DMA = 1;
	localparam int unsigned REQ_CPU0 = 2;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 26;

	// ***********************************************
	// Cycle lengths in states and go widths
	// ***********************************************
	localparam logic [3:0] LEN_RFSH = 4'h8;
	localparam logic [3:0] LEN_WR32 = 4'h8;
	localparam logic [3:0] LEN_RD_OK = 4'ha;
	localparam logic [3:0] LEN_RD_ERR = 4'hd;
	localparam logic [3:0] LEN_RMW = 4'hf;
	localparam logic [3:0] GO_LEN = 4'h5;
	localparam logic [3:0] GO_LEN_WR32 = 4'h6;
	localparam logic [3:0] ST_ANY_ERR = 4'h9;
	localparam logic [3:0] ST_UC_ERR = 4'ha;
	// State at which the error outcome of a read is known
	localparam logic [3:0] ST_ERR_KNOWN = 4'h8;
	localparam logic [3:0] BYTE_ALL = 4'hf;

	// ***********************************************
	// Function codes, active low, lower two bits
	// ***********************************************
	localparam logic [1:0] FC_RMW = 2'h0;
	localparam logic [1:0] FC_WR32 = 2'h1;
	localparam logic [1:0] FC_READ = 2'h2;
	localparam logic [1:0] FC_NOP = 2'h3;

	typedef enum logic [2:0] {
		MBAC_CYC_RFSH,
		MBAC_CYC_WR32,
		MBAC_CYC_READ,
		MBAC_CYC_RMW,
		MBAC_CYC_NONE
	} mbac_cyc_t;

	// Bus qualifiers sampled to classify a cycle
	typedef struct packed {
		logic [3:0] byte_sel;
		logic bus_read;
		logic dma_read;
	} mbac_busq_t;

	// Memory error report from the correction logic
	typedef struct packed {
		logic corr;
		logic uncorr;
	} mbac_err_t;

	// Grant outputs, active low like the request lines
	typedef struct packed {
		logic refresh_grant_n;
		logic dma_grant_n;
		logic [3:0] cpu_grant_n;
	} mbac_grant_t;
endpackage
`default_nettype wire

//--- rtl/mbac_prio.sv
`timescale 1ns/1ns
`default_nettype none
module mbac_prio (
	input wire logic [mbac_pkg::NUM_REQ-1:0] req_in,
	output logic [mbac_pkg::NUM_REQ-1:0] win_out
);
	import mbac_pkg::*;

	// ***********************************************
	// Fixed priority, lowest index wins
	// ***********************************************
	wire logic [NUM_REQ-1:0] lower_mask;
	assign lower_mask = req_in - 6'h01;
	assign win_out = req_in & ~lower_mask;
endmodule
`default_nettype wire

//--- rtl/mbac_fcode.sv
`timescale 1ns/1ns
`default_nettype none
module mbac_fcode (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic load_in,
	input wire logic idle_in,
	input wire logic rfsh_in,
	input wire mbac_pkg::mbac_busq_t busq_in,
	output mbac_pkg::mbac_cyc_t cyc_out,
	output logic [1:0] code_out
);
	import mbac_pkg::*;

	// ***********************************************
	// Function code state machine
	// ***********************************************
	mbac_cyc_t cyc_r;
	mbac_cyc_t cyc_nxt;
	wire logic rd_any;
	wire logic full_word;
	assign rd_any = busq_in.bus_read | busq_in.dma_read;
	assign full_word = busq_in.byte_sel == BYTE_ALL;

	always_comb begin
		cyc_nxt = cyc_r;
		if (load_in) begin
			if (rfsh_in)
				cyc_nxt = MBAC_CYC_RFSH;
			else if (rd_any)
				cyc_nxt = MBAC_CYC_READ;
			else if (full_word)
				cyc_nxt = MBAC_CYC_WR32;
			else
				cyc_nxt = MBAC_CYC_RMW;
		end else if (idle_in) begin
			cyc_nxt = MBAC_CYC_NONE;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in)
			cyc_r <= MBAC_CYC_NONE;
		else
			cyc_r <= cyc_nxt;
	end

	always_comb begin
		unique case (cyc_r)
		MBAC_CYC_RMW: code_out = FC_RMW;
		MBAC_CYC_WR32: code_out = FC_WR32;
		MBAC_CYC_READ: code_out = FC_READ;
		default: code_out = FC_NOP;
		endcase
	end
	assign cyc_out = cyc_r;
endmodule
`default_nettype wire

//--- dv/mbac_req_model.sv
`timescale 1ns/1ns
`default_nettype none
module mbac_req_model (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [5:0] start_in,
	input wire logic [5:0] grant_n_in,
	output logic [5:0] req_n_out
);
	// ***********************************************
	// Requesters: bit 0 refresh, 1 DMA, 2-5 cpu0-3
	// ***********************************************
	// Request held until granted, dropped the clock after grant is seen,
	// so a late release never looks like a second request
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			req_n_out <= 6'h3f;
		end else begin
			req_n_out <= (req_n_out & ~start_in)
				| ~grant_n_in;
		end
	end
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import mbac_pkg::*;
	logic ref_clk_in;
	logic nrst_in;
	logic [5:0] start;
	logic [5:0] req_n;
	logic [5:0] gnt_n;
	mbac_busq_t busq;
	mbac_err_t err;
	mbac_grant_t grant;
	logic go, done_n, rf_n, fc1_n, fc0_n, uc_n, any;
	int n_fail;
	int n_tests;

	assign gnt_n = {grant.cpu_grant_n, grant.dma_grant_n,
		grant.refresh_grant_n};

	mbac_top dut_u (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.refresh_request_n_in(req_n[0]),
		.dma_request_n_in(req_n[1]),
		.cpu_request_n_in(req_n[5:2]),
		.busq_in(busq),
		.mem_err_in(err),
		.grant_out(grant),
		.cycle_go_out(go),
		.cycle_done_n_out(done_n),
		.refresh_func_code_n_out(rf_n),
		.func_code_bit1_n_out(fc1_n),
		.func_code_bit0_n_out(fc0_n),
		.uncorrectable_error_n_out(uc_n),
		.any_error_out(any)
	);

	mbac_req_model model_u (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.start_in(start),
		.grant_n_in(gnt_n),
		.req_n_out(req_n)
	);

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// ***********************************************
	// Checking and closing
	// ***********************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Bounded, so a lost grant ends the run instead of hanging
	task automatic await_grant(input int idx, output int t);
		t = 0;
		do begin
			@(posedge ref_clk_in);
			#1;
			t++;
		end while (gnt_n[idx] !== 1'b0 && t < 40);
		if (t >= 40) begin
			check(8'h00, 8'h01);
			give_verdict();
		end
	endtask

	// Walks one cycle from S0 up to and including its done state
	task automatic measure(output int ds, output int gs, output int as_,
			output int us, output int un, output logic [1:0] code);
		gs = 0;
		as_ = -1;
		us = -1;
		un = 0;
		ds = -1;
		code = 2'b00;
		for (int s = 0; s < 20 && ds < 0; s++) begin
			check({7'h00, rf_n}, {7'h00, gnt_n[0]});
			if (go === 1'b1) gs++;
			if (any === 1'b1) as_ = s;
			if (uc_n === 1'b0) un++;
			if (uc_n === 1'b0 && us < 0) us = s;
			if (s == 2) code = {fc1_n, fc0_n};
			if (done_n === 1'b0) begin
				ds = s;
			end else begin
				@(posedge ref_clk_in);
				#1;
			end
		end
	endtask

	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic run(input int idx, input logic [5:0] bq,
			input logic [1:0] e, input int len, input int glen,
			input logic [1:0] fc);
		int t, ds, gs, as_, us, un;
		logic [1:0] code;
		logic [5:0] m;
		m = 6'h01 << idx;
		@(posedge ref_clk_in);
		start <= m;
		busq <= bq;
		err <= e;
		@(posedge ref_clk_in);
		start <= 6'h00;
		await_grant(idx, t);
		check(8'(t), 8'h02);
		check({2'b00, gnt_n}, {2'b00, ~m});
		measure(ds, gs, as_, us, un, code);
		check(8'(ds), 8'(len - 1));
		check(8'(gs), 8'(glen));
		if (idx != 0) check({6'h00, code}, {6'h00, fc});
		check(8'(as_), (e != 2'b00) ? 8'h09 : 8'hff);
		check(8'(us), e[0] ? 8'h0a : 8'hff);
		check(8'(un), e[0] ? 8'(len - 10) : 8'h00);
		@(posedge ref_clk_in);
		#1;
		check({6'h00, fc1_n, fc0_n}, 8'h03);
		check({7'h00, done_n}, 8'h01);
	endtask

	// Reset in mid-cycle: all back to idle, the next request is served
	task automatic mid_reset();
		@(posedge ref_clk_in);
		start <= 6'h04;
		busq <= 6'h02;
		err <= 2'b00;
		@(posedge ref_clk_in);
		start <= 6'h00;
		repeat (4) @(posedge ref_clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1;
		check({2'b00, gnt_n}, 8'h3f);
		check({6'h00, go, done_n}, 8'h01);
		check({6'h00, fc1_n, fc0_n}, 8'h03);
		check({6'h00, uc_n, any}, 8'h02);
		check({7'h00, rf_n}, 8'h01);
		@(posedge ref_clk_in);
		nrst_in <= 1'b1;
	endtask

	// All six at once: served in order, back to back, none cut short
	task automatic prio();
		int t, ds, gs, as_, us, un;
		logic [1:0] code;
		logic [5:0] m;
		@(posedge ref_clk_in);
		start <= 6'h3f;
		busq <= 6'h02;
		err <= 2'b00;
		@(posedge ref_clk_in);
		start <= 6'h00;
		for (int k = 0; k < 6; k++) begin
			m = 6'h01 << k;
			await_grant(k, t);
			check(8'(t), (k == 0) ? 8'h02 : 8'h01);
			check({2'b00, gnt_n}, {2'b00, ~m});
			measure(ds, gs, as_, us, un, code);
			check(8'(ds), (k == 0) ? 8'h07 : 8'h09);
		end
	endtask

	initial begin
		n_fail = 0;
		n_tests = 0;
		nrst_in = 1'b0;
		start = 6'h00;
		busq = 6'h00;
		err = 2'b00;
		repeat (8) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		run(2, 6'h02, 2'b00, 10, 5, 2'b10);
		mid_reset();
		run(2, 6'h02, 2'b10, 13, 5, 2'b10);
		run(3, 6'h02, 2'b01, 13, 5, 2'b10);
		run(4, 6'h3c, 2'b00, 8, 6, 2'b01);
		run(5, 6'h0c, 2'b00, 15, 5, 2'b00);
		run(5, 6'h0c, 2'b01, 15, 5, 2'b00);
		run(0, 6'h02, 2'b00, 8, 5, 2'b11);
		run(1, 6'h01, 2'b00, 10, 5, 2'b10);
		prio();
		give_verdict();
	end
endmodule
`default_nettype wire
